//--- include/tju_pkg.sv
package tju_pkg;

   // ---------------------------------------------------------------
   // Widths and control register layout
   // ---------------------------------------------------------------
   localparam int          XLEN            = 32;
   localparam int          BASE_LSB        = 6;
   localparam int          MODE_W          = 6;
   localparam logic [11:0] CSR_TJ_ADDR     = 12'h017;
   localparam logic [5:0]  MODE_JUMP_TABLE = 6'h00;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Encoding of the compressed table jump
   // ---------------------------------------------------------------
   localparam logic [2:0]  ENC_FUNCT3      = 3'h5;
   localparam logic [2:0]  ENC_ZERO        = 3'h0;
   localparam logic [1:0]  ENC_QUADRANT    = 2'h2;
   localparam logic [7:0]  LINK_INDEX_MIN  = 8'h20;
   localparam int          ENTRY_SHIFT     = 2;
   localparam logic [31:0] INSTR_BYTES     = 32'h0000_0002;
   localparam logic [31:0] TARGET_MASK     = 32'hFFFF_FFFE;

   // ---------------------------------------------------------------
   // Trap causes and privilege levels
   // ---------------------------------------------------------------
   localparam logic [31:0] CAUSE_ILLEGAL   = 32'h0000_0002;
   localparam logic [31:0] CAUSE_VIRTUAL   = 32'h0000_0016;
   localparam logic [31:0] TVAL_NONE       = 32'h0000_0000;
   localparam logic [1:0]  PRIV_U          = 2'h0;
   localparam logic [1:0]  PRIV_M          = 2'h3;

   typedef enum logic [0:0] {
      TJU_IDLE  = 1'b0,
      TJU_FETCH = 1'b1
   } tju_state_t;

   typedef enum logic [1:0] {
      TJU_GATE_OK      = 2'h0,
      TJU_GATE_ILLEGAL = 2'h1,
      TJU_GATE_VIRTUAL = 2'h2
   } tju_gate_t;

endpackage

//--- rtl/tju_table_jump_unit.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Base comes from control register; each entry is one XLEN-bit word.
// - Two fetches, opcode then entry; entry needs execute, never read.
// - Entry fetch is flagged so triggers and breakpoints ignore it.
// - Fetch fault traps with instruction PC, fault cause, faulting address.
// - Control register sits at address 0x0017, user read and write.
// - Base field in bits 31..6, mode in bits 5..0, legal values only.
// - Base is 64-byte aligned; low six bits read zero.
// - Register always present; writable value set is our choice.
// - Base is virtual and translated when virtual memory is on.
// - Mode zero is jump table mode; writes keep only implemented modes.
// - Reserved mode makes both table jumps reserved encodings.
// - Clear state-enable bit 2 traps access and jumps below machine level.
// - Index below 32 decodes as the non-linking jump.
// - Index 32 or above decodes as the linking jump.
// - Entry address is base plus index shifted left by two.
// - Non-linking jump goes to entry value with bit 0 cleared.
// - Linking jump also puts next instruction address in return register.
// - Entries are read in current data endianness.
// - Linking jump pushes the return-address stack like a call.
module tju_table_jump_unit (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_instr_valid,
   input  wire logic [15:0] i_instr,
   input  wire logic [31:0] i_instr_pc,
   input  wire logic        i_instr_fault,
   input  wire logic [31:0] i_instr_fault_cause,
   input  wire logic [31:0] i_instr_fault_tval,
   output logic             o_instr_ready,
   output logic             o_instr_match,
   input  wire logic [1:0]  i_priv,
   input  wire logic        i_virt,
   input  wire logic        i_mstateen_jt,
   input  wire logic        i_hstateen_jt,
   input  wire logic        i_sstateen_jt,
   input  wire logic        i_data_big_endian,
   input  wire logic        i_vm_enable,
   output logic             o_fetch_req,
   output logic [31:0]      o_fetch_addr,
   output logic             o_fetch_exec_check,
   output logic             o_fetch_translate,
   output logic             o_fetch_no_trigger,
   input  wire logic        i_fetch_ack,
   input  wire logic [31:0] i_fetch_rdata,
   input  wire logic        i_fetch_fault,
   input  wire logic [31:0] i_fetch_fault_cause,
   input  wire logic        i_csr_req,
   input  wire logic        i_csr_we,
   input  wire logic [11:0] i_csr_addr,
   input  wire logic [31:0] i_csr_wdata,
   output logic             o_csr_ack,
   output logic             o_csr_hit,
   output logic [31:0]      o_csr_rdata,
   output logic             o_csr_illegal,
   output logic             o_csr_virtual,
   output logic             o_jump_valid,
   output logic [31:0]      o_jump_target,
   output logic             o_link_we,
   output logic [31:0]      o_link_data,
   output logic             o_ras_push,
   output logic             o_trap_valid,
   output logic [31:0]      o_trap_epc,
   output logic [31:0]      o_trap_cause,
   output logic [31:0]      o_trap_tval
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic is_table_jump(input logic [15:0] instr);
      is_table_jump = (instr[15:13] == tju_pkg::ENC_FUNCT3) &&
                      (instr[12:10] == tju_pkg::ENC_ZERO) &&
                      (instr[1:0] == tju_pkg::ENC_QUADRANT);
   endfunction

   // Same gate for register access and for execution
   function automatic tju_pkg::tju_gate_t gate_check(
      input logic [1:0] priv,
      input logic       virt,
      input logic       m_en,
      input logic       h_en,
      input logic       s_en
   );
      if (priv == tju_pkg::PRIV_M) begin
         gate_check = tju_pkg::TJU_GATE_OK;
      end else if (!m_en) begin
         gate_check = tju_pkg::TJU_GATE_ILLEGAL;
      end else if (virt && !h_en) begin
         gate_check = tju_pkg::TJU_GATE_VIRTUAL;
      end else if ((priv == tju_pkg::PRIV_U) && !s_en) begin
         gate_check = virt ? tju_pkg::TJU_GATE_VIRTUAL
                           : tju_pkg::TJU_GATE_ILLEGAL;
      end else begin
         gate_check = tju_pkg::TJU_GATE_OK;
      end
   endfunction

   // Fetch path returns bytes in little-endian lane order
   function automatic logic [31:0] to_data_endian(
      input logic [31:0] word,
      input logic        big
   );
      to_data_endian = big ? {word[7:0], word[15:8], word[23:16],
                              word[31:24]} : word;
   endfunction

   // Only jump table mode is implemented
   function automatic logic mode_implemented(input logic [5:0] mode);
      mode_implemented = (mode == tju_pkg::MODE_JUMP_TABLE);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   tju_pkg::tju_state_t state;
   tju_pkg::tju_state_t next_state;
   logic [31:tju_pkg::BASE_LSB]  base;
   logic [31:tju_pkg::BASE_LSB]  next_base;
   logic [tju_pkg::MODE_W-1:0]   mode;
   logic [tju_pkg::MODE_W-1:0]   next_mode;
   logic [31:0]                  pc_hold;
   logic [31:0]                  next_pc_hold;
   logic                         link_hold;
   logic                         next_link_hold;
   logic [31:0]                  next_fetch_addr;
   logic                         next_csr_ack;
   logic                         next_csr_hit;
   logic [31:0]                  next_csr_rdata;
   logic                         next_csr_illegal;
   logic                         next_csr_virtual;
   logic                         next_jump_valid;
   logic [31:0]                  next_jump_target;
   logic                         next_link_we;
   logic [31:0]                  next_link_data;
   logic                         next_ras_push;
   logic                         next_trap_valid;
   logic [31:0]                  next_trap_epc;
   logic [31:0]                  next_trap_cause;
   logic [31:0]                  next_trap_tval;

   tju_pkg::tju_gate_t           gate;
   logic [31:0]                  ctrl_value;
   logic [31:0]                  entry_word;
   logic [7:0]                   index;

   assign gate          = gate_check(i_priv, i_virt, i_mstateen_jt,
                                     i_hstateen_jt, i_sstateen_jt);
   assign ctrl_value    = {base, mode};
   assign entry_word    = to_data_endian(i_fetch_rdata, i_data_big_endian);
   assign index         = i_instr[9:2];
   assign o_instr_ready = (state == tju_pkg::TJU_IDLE);
   assign o_instr_match = is_table_jump(i_instr);

   // ---------------------------------------------------------------
   // Entry fetch attributes
   // ---------------------------------------------------------------
   assign o_fetch_req        = (state == tju_pkg::TJU_FETCH);
   assign o_fetch_exec_check = 1'b1;
   assign o_fetch_translate  = i_vm_enable;
   assign o_fetch_no_trigger = 1'b1;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_state       = state;
      next_base        = base;
      next_mode        = mode;
      next_pc_hold     = pc_hold;
      next_link_hold   = link_hold;
      next_fetch_addr  = o_fetch_addr;
      next_csr_ack     = 1'b0;
      next_csr_hit     = 1'b0;
      next_csr_rdata   = o_csr_rdata;
      next_csr_illegal = 1'b0;
      next_csr_virtual = 1'b0;
      next_jump_valid  = 1'b0;
      next_jump_target = o_jump_target;
      next_link_we     = 1'b0;
      next_link_data   = o_link_data;
      next_ras_push    = 1'b0;
      next_trap_valid  = 1'b0;
      next_trap_epc    = o_trap_epc;
      next_trap_cause  = o_trap_cause;
      next_trap_tval   = o_trap_tval;

      // Register access, independent of an entry fetch in flight
      if (i_csr_req) begin
         next_csr_ack = 1'b1;
         if (i_csr_addr == tju_pkg::CSR_TJ_ADDR) begin
            next_csr_hit = 1'b1;
            if (gate == tju_pkg::TJU_GATE_ILLEGAL) begin
               next_csr_illegal = 1'b1;
               next_csr_rdata   = tju_pkg::TVAL_NONE;
            end else if (gate == tju_pkg::TJU_GATE_VIRTUAL) begin
               next_csr_virtual = 1'b1;
               next_csr_rdata   = tju_pkg::TVAL_NONE;
            end else begin
               next_csr_rdata = ctrl_value;
               if (i_csr_we) begin
                  next_base = i_csr_wdata[31:tju_pkg::BASE_LSB];
                  if (mode_implemented(
                         i_csr_wdata[tju_pkg::MODE_W-1:0])) begin
                     next_mode = i_csr_wdata[tju_pkg::MODE_W-1:0];
                  end
               end
            end
         end else begin
            next_csr_rdata = tju_pkg::TVAL_NONE;
         end
      end

      case (state)
         tju_pkg::TJU_IDLE: begin
            if (i_instr_valid && is_table_jump(i_instr)) begin
               next_pc_hold   = i_instr_pc;
               next_link_hold = (index >= tju_pkg::LINK_INDEX_MIN);
               if (i_instr_fault) begin
                  next_trap_valid = 1'b1;
                  next_trap_epc   = i_instr_pc;
                  next_trap_cause = i_instr_fault_cause;
                  next_trap_tval  = i_instr_fault_tval;
               end else if (gate != tju_pkg::TJU_GATE_OK) begin
                  next_trap_valid = 1'b1;
                  next_trap_epc   = i_instr_pc;
                  next_trap_cause = (gate == tju_pkg::TJU_GATE_VIRTUAL)
                                    ? tju_pkg::CAUSE_VIRTUAL
                                    : tju_pkg::CAUSE_ILLEGAL;
                  next_trap_tval  = tju_pkg::TVAL_NONE;
               end else if (!mode_implemented(mode)) begin
                  // Reserved mode: not a table jump at all
                  next_trap_valid = 1'b1;
                  next_trap_epc   = i_instr_pc;
                  next_trap_cause = tju_pkg::CAUSE_ILLEGAL;
                  next_trap_tval  = tju_pkg::TVAL_NONE;
               end else begin
                  next_fetch_addr = {base, {tju_pkg::BASE_LSB{1'b0}}} +
                     {22'h00_0000, index,
                      {tju_pkg::ENTRY_SHIFT{1'b0}}};
                  next_state = tju_pkg::TJU_FETCH;
               end
            end
         end
         tju_pkg::TJU_FETCH: begin
            // Nothing architectural moves until the entry is back
            if (i_fetch_ack) begin
               next_state = tju_pkg::TJU_IDLE;
               if (i_fetch_fault) begin
                  next_trap_valid = 1'b1;
                  next_trap_epc   = pc_hold;
                  next_trap_cause = i_fetch_fault_cause;
                  next_trap_tval  = o_fetch_addr;
               end else begin
                  next_jump_valid  = 1'b1;
                  next_jump_target = entry_word &
                                     tju_pkg::TARGET_MASK;
                  next_link_we     = link_hold;
                  next_link_data   = pc_hold + tju_pkg::INSTR_BYTES;
                  next_ras_push    = link_hold;
               end
            end
         end
         default: begin
            next_state = tju_pkg::TJU_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state         <= tju_pkg::TJU_IDLE;
         base          <= tju_pkg::CTRL_RESET[31:tju_pkg::BASE_LSB];
         mode          <= tju_pkg::CTRL_RESET[tju_pkg::MODE_W-1:0];
         pc_hold       <= 32'h0000_0000;
         link_hold     <= 1'b0;
         o_fetch_addr  <= 32'h0000_0000;
         o_csr_ack     <= 1'b0;
         o_csr_hit     <= 1'b0;
         o_csr_rdata   <= 32'h0000_0000;
         o_csr_illegal <= 1'b0;
         o_csr_virtual <= 1'b0;
         o_jump_valid  <= 1'b0;
         o_jump_target <= 32'h0000_0000;
         o_link_we     <= 1'b0;
         o_link_data   <= 32'h0000_0000;
         o_ras_push    <= 1'b0;
         o_trap_valid  <= 1'b0;
         o_trap_epc    <= 32'h0000_0000;
         o_trap_cause  <= 32'h0000_0000;
         o_trap_tval   <= 32'h0000_0000;
      end else begin
         state         <= next_state;
         base          <= next_base;
         mode          <= next_mode;
         pc_hold       <= next_pc_hold;
         link_hold     <= next_link_hold;
         o_fetch_addr  <= next_fetch_addr;
         o_csr_ack     <= next_csr_ack;
         o_csr_hit     <= next_csr_hit;
         o_csr_rdata   <= next_csr_rdata;
         o_csr_illegal <= next_csr_illegal;
         o_csr_virtual <= next_csr_virtual;
         o_jump_valid  <= next_jump_valid;
         o_jump_target <= next_jump_target;
         o_link_we     <= next_link_we;
         o_link_data   <= next_link_data;
         o_ras_push    <= next_ras_push;
         o_trap_valid  <= next_trap_valid;
         o_trap_epc    <= next_trap_epc;
         o_trap_cause  <= next_trap_cause;
         o_trap_tval   <= next_trap_tval;
      end
   end

endmodule

//--- testbench/tju_properties.sv
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module tju_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   input wire logic        i_instr_valid,
   input wire logic        o_instr_ready,
   input wire logic        o_instr_match,
   input wire logic        i_vm_enable,
   input wire logic        o_fetch_req,
   input wire logic [31:0] o_fetch_addr,
   input wire logic        o_fetch_exec_check,
   input wire logic        o_fetch_translate,
   input wire logic        o_fetch_no_trigger,
   input wire logic        i_fetch_ack,
   input wire logic        i_csr_req,
   input wire logic        o_csr_ack,
   input wire logic        o_csr_hit,
   input wire logic [31:0] o_csr_rdata,
   input wire logic        o_jump_valid,
   input wire logic [31:0] o_jump_target,
   input wire logic        o_link_we,
   input wire logic        o_ras_push,
   input wire logic        o_trap_valid
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_take;
      o_instr_ready && i_instr_valid && o_instr_match;
   endsequence
   sequence s_ack;
      o_fetch_req && i_fetch_ack;
   endsequence

   a_csr_ack_follows: assert property (
      i_csr_req |=> o_csr_ack) else $error("access not answered");
   a_csr_low_zero: assert property (
      o_csr_ack && o_csr_hit |-> o_csr_rdata[5:0] == 6'h00)
      else $error("base not aligned");
   a_csr_miss_zero: assert property (
      o_csr_ack && !o_csr_hit |-> o_csr_rdata == 32'h0000_0000)
      else $error("miss returned data");
   a_fetch_exec_only: assert property (
      o_fetch_req |-> o_fetch_exec_check && o_fetch_no_trigger)
      else $error("entry fetch qualifiers wrong");
   a_take_starts: assert property (
      s_take |=> o_fetch_req || o_trap_valid)
      else $error("taken jump did nothing");
   a_ack_ends: assert property (
      s_ack |=> (o_jump_valid != o_trap_valid) && o_instr_ready)
      else $error("entry response not finished");
   a_addr_stable: assert property (
      o_fetch_req && $past(o_fetch_req) |-> $stable(o_fetch_addr))
      else $error("entry address moved");
   a_jump_after_ack: assert property (
      o_jump_valid |-> $past(o_fetch_req && i_fetch_ack))
      else $error("jump without entry");
   a_target_even: assert property (
      o_jump_valid |-> !o_jump_target[0]) else $error("target odd");
   a_link_push: assert property (
      o_link_we |-> o_ras_push && o_jump_valid)
      else $error("link without push");
   a_translate_vm: assert property (
      o_fetch_req |-> o_fetch_translate == i_vm_enable)
      else $error("translation flag wrong");
endmodule

//--- testbench/tju_fetch_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Entry memory on the fetch path
// ----------------------------------------
module tju_fetch_model #(
   parameter logic [31:0] FAULT_CAUSE = 32'h0000_0001
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_fetch_req,
   input  wire logic [31:0] i_fetch_addr,
   input  wire logic [1:0]  i_delay,
   input  wire logic [31:0] i_fault_addr,
   output logic             o_ack,
   output logic [31:0]      o_rdata,
   output logic             o_fault,
   output logic [31:0]      o_cause
);
   logic [1:0]  cnt;
   logic [31:0] ent;

   // Fixed words derived from the address; never rewritten, so no barrier
   assign ent = {~i_fetch_addr[15:0], i_fetch_addr[15:0]} | 32'h0000_0001;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || o_ack || !i_fetch_req) begin
         o_ack <= 1'b0;
         cnt   <= 2'h0;
      end else if (cnt == i_delay) begin
         o_ack <= 1'b1;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
   // Outside the answer the data is inverted, so stale words never match
   assign o_rdata = o_ack ? ent : ~ent;
   assign o_fault = o_ack && (i_fetch_addr == i_fault_addr);
   assign o_cause = o_fault ? FAULT_CAUSE : ~FAULT_CAUSE;
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   localparam logic [31:0] ONE = 32'h0000_0001, ZERO = 32'h0000_0000;
   localparam logic [31:0] F_CAUSE = 32'h0000_0001;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0;
   logic i_instr_fault = 1'b0, i_virt = 1'b0, i_csr_req = 1'b0;
   logic i_mstateen_jt = 1'b1, i_hstateen_jt = 1'b1, i_sstateen_jt = 1'b1;
   logic i_data_big_endian = 1'b0, i_vm_enable = 1'b0, i_csr_we = 1'b0;
   logic [1:0]  i_priv = 2'h0, dly = 2'h0;
   logic [11:0] i_csr_addr = 12'h000;
   logic [15:0] i_instr = 16'h0000;
   logic [31:0] i_instr_pc = ZERO, i_instr_fault_cause = ZERO;
   logic [31:0] i_instr_fault_tval = ZERO, i_csr_wdata = ZERO;
   logic [31:0] flt_a = ZERO, base = ZERO;
   logic        i_fetch_ack, i_fetch_fault, o_instr_ready, o_instr_match;
   logic        o_fetch_req, o_fetch_exec_check, o_fetch_translate;
   logic        o_fetch_no_trigger, o_csr_ack, o_csr_hit, o_csr_illegal;
   logic        o_csr_virtual, o_jump_valid, o_link_we, o_ras_push;
   logic        o_trap_valid;
   logic [31:0] i_fetch_rdata, i_fetch_fault_cause, o_fetch_addr;
   logic [31:0] o_csr_rdata, o_jump_target, o_link_data, o_trap_epc;
   logic [31:0] o_trap_cause, o_trap_tval;
   int          n_errors = 0, n_checks = 0, i;
   logic [7:0]  r_idx [6] = '{8'h00, 8'h1F, 8'h20, 8'h21, 8'hFF, 8'h07};
   logic [31:0] r_pc [6] = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0300,
                             32'h0000_03FE, 32'h0000_0FFE, 32'h0000_0080};
   logic        r_be [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [1:0]  r_dly [6] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h2, 2'h0};
   logic [5:0]  g_in [3] = '{6'h03, 6'h1D, 6'h06};
   logic [31:0] g_c [3] = '{32'h0000_0002, 32'h0000_0016, 32'h0000_0002};
   logic [2:0]  g_f [3] = '{3'h2, 3'h1, 3'h2};

   tju_table_jump_unit tju_table_jump_unit_i (.*);
   tju_fetch_model #(.FAULT_CAUSE(F_CAUSE)) tju_fetch_model_i (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fetch_req(o_fetch_req),
      .i_fetch_addr(o_fetch_addr), .i_delay(dly), .i_fault_addr(flt_a),
      .o_ack(i_fetch_ack), .o_rdata(i_fetch_rdata),
      .o_fault(i_fetch_fault), .o_cause(i_fetch_fault_cause));

   initial forever #50 i_sys_clk = ~i_sys_clk;

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Flags expected are {hit, illegal, virtual}
   task csr(input logic we, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] er, input logic [2:0] ef);
      @(negedge i_sys_clk);
      {i_csr_req, i_csr_we, i_csr_addr, i_csr_wdata} = {1'b1, we, a, d};
      @(negedge i_sys_clk);
      i_csr_req = 1'b0;
      chk("csr_flags", 32'({1'b1, ef[1:0]}),
          32'({o_csr_ack, o_csr_illegal, o_csr_virtual}));
      if (ef[1:0] == 2'h0) chk("csr_hit", 32'(ef[2]), 32'(o_csr_hit));
      chk("csr_rdata", er, o_csr_rdata);
   endtask

   task run(input logic [15:0] ins, input logic [31:0] pc,
            input logic tr, input logic [31:0] c, input logic [31:0] tv);
      logic [31:0] ea, e, fa;
      int k;
      ea = base + (32'(ins[9:2]) << 2);
      e = {~ea[15:0], ea[15:0]} | ONE;
      if (i_data_big_endian) e = {e[7:0], e[15:8], e[23:16], e[31:24]};
      fa = ZERO;
      @(negedge i_sys_clk);
      {i_instr, i_instr_pc, i_instr_valid} = {ins, pc, 1'b1};
      @(negedge i_sys_clk);
      i_instr_valid = 1'b0;
      for (k = 0; k < 20 && !(o_jump_valid || o_trap_valid); k++) begin
         if (o_fetch_req) fa = o_fetch_addr;
         @(negedge i_sys_clk);
      end
      if (tr) begin
         chk("trap_valid", ONE, 32'(o_trap_valid));
         chk("trap_epc", pc, o_trap_epc);
         chk("trap_cause", c, o_trap_cause);
         chk("trap_tval", tv, o_trap_tval);
         chk("jump_valid", ZERO, 32'(o_jump_valid));
      end else begin
         chk("fetch_addr", ea, fa);
         chk("jump_target", e & 32'hFFFF_FFFE, o_jump_target);
         chk("jump_valid", ONE, 32'(o_jump_valid));
         chk("link_we", 32'(ins[9:2] >= 8'h20),
             32'(o_link_we));
         chk("ras_push", 32'(ins[9:2] >= 8'h20), 32'(o_ras_push));
         if (ins[9:2] >= 8'h20)
            chk("link_data", pc + 32'h0000_0002, o_link_data);
      end
   endtask

   initial begin
      #200000;
      n_errors++;
      give_verdict;
   end

   initial begin
      repeat (5) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_rst = 1'b0;
      chk("ready", ONE, 32'(o_instr_ready));
      csr(1'b1, 12'h017, 32'h1234_5647, ZERO, 3'h4);
      csr(1'b1, 12'h018, 32'hFFFF_FFFF, ZERO, 3'h0);
      csr(1'b0, 12'h017, ZERO, 32'h1234_5640, 3'h4);
      base = 32'h1234_5640;
      $display("test register done");
      for (i = 0; i < 6; i++) begin
         dly = r_dly[i];
         i_data_big_endian = r_be[i];
         i_vm_enable = r_be[i];
         run({3'h5, 3'h0, r_idx[i], 2'h2}, r_pc[i], 1'b0, ZERO, ZERO);
      end
      $display("test table done");
      dly = 2'h1;
      flt_a = base + 32'h0000_000C;
      run(16'hA00E, 32'h0000_0400, 1'b1, F_CAUSE, flt_a);
      flt_a = ZERO;
      {i_instr_fault, i_instr_fault_cause} = {1'b1, 32'h0000_000C};
      i_instr_fault_tval = 32'h0000_0502;
      run(16'hA00E, 32'h0000_0500, 1'b1, 32'h0000_000C, 32'h0000_0502);
      i_instr_fault = 1'b0;
      $display("test fault done");
      for (i = 0; i < 3; i++) begin
         {i_priv, i_virt, i_mstateen_jt, i_hstateen_jt, i_sstateen_jt} = g_in[i];
         run(16'hA00E, 32'h0000_0600, 1'b1, g_c[i], ZERO);
         csr(1'b1, 12'h017, ZERO, ZERO, g_f[i]);
      end
      {i_priv, i_virt, i_mstateen_jt, i_hstateen_jt, i_sstateen_jt} = 6'h30;
      run(16'hA08E, 32'h0000_0700, 1'b0, ZERO, ZERO);
      csr(1'b0, 12'h017, ZERO, base, 3'h4);
      $display("test gate done");
      // Reset in the middle of an entry fetch
      dly = 2'h3;
      @(negedge i_sys_clk);
      {i_instr, i_instr_pc, i_instr_valid} = {16'hA00E, 32'h0000_0800, 1'b1};
      @(negedge i_sys_clk);
      {i_instr_valid, i_rst} = 2'b01;
      chk("fetch_req", ONE, 32'(o_fetch_req));
      @(negedge i_sys_clk);
      i_rst = 1'b0;
      chk("reset_state", 32'h0000_0004,
          32'({o_instr_ready, o_fetch_req, o_jump_valid}));
      csr(1'b0, 12'h017, ZERO, ZERO, 3'h4);
      $display("test reset done");
      @(negedge i_sys_clk);
      {i_instr, i_instr_valid} = {16'hA482, 1'b1};
      #10;
      chk("match", ZERO, 32'(o_instr_match));
      @(negedge i_sys_clk);
      i_instr = 16'hA081;
      #10;
      chk("match", ZERO, 32'(o_instr_match));
      @(negedge i_sys_clk);
      i_instr_valid = 1'b0;
      chk("ignored", ZERO, 32'({o_fetch_req, o_trap_valid}));
      $display("test decode done");
      give_verdict;
   end
endmodule

bind tju_table_jump_unit tju_checker tju_checker_i (.*);
